// ===== rtl/nvm_device.sv
// Contract
// - station address in top six bytes, msb first
// - last sector erases like any other
// - program only clears bits
// - erase clears addressed 512-byte sector
// - hardware timing, registers stay accessible
// - interrupt on operation completion
// - host writes both key codes first
// - missing unlock locks out until reset
// - reads need no unlock
// - erase bit zero write starts erase
// - host erases before reprogramming byte
// - data read returns byte at address
// - auto-read returns byte then increments
// - busy bit shows operation running
// - status bits show last operation type
// - status upper nibble reads zero
// - key register write-only
// - sixteen-bit address from two registers
// - host resets after programming
// - host writes reserved erase bit zero
module nvm_device #(
  parameter int unsigned PROGRAM_CNT = nvm_pkg::PROGRAM_CYCLES,
  parameter int unsigned ERASE_CNT = nvm_pkg::ERASE_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // host bus
  nvm_host_if.device bus
);
  import nvm_pkg::*;

  typedef struct packed {
    logic [15:0] addr;
    lock_t lock;
    logic last_prog;
    logic last_erase;
    logic op_erase;
    logic [MEM_AW-1:0] op_idx;
    logic [7:0] pdata;
    logic [7:0] rdata;
    logic irq;
  } dev_t;
  dev_t s_r, s_nxt;

  // array bytes, kept across reset
  logic [7:0] mem_r [MEM_BYTES];
  // timer handshake and access decode
  logic tmr_start, tmr_busy, tmr_done;
  logic [TIMER_W-1:0] tmr_cycles;
  logic prog_req, erase_req, any_req;
  logic [MEM_AW-1:0] cur_idx;
  logic [7:0] status_val;
  logic [7:0] rd_val;
  logic [15:0] addr_nxt;
  lock_t key_lock;
  // erase strobes, one per sector of the array
  localparam int unsigned SECTORS = MEM_BYTES >> SECTOR_AW;
  wire [SECTORS-1:0] sector_wipe;
  logic prog_wr;

  // access decode; a start counts only while the timer is idle
  assign cur_idx = s_r.addr[MEM_AW-1:0];
  assign prog_req = bus.wr && bus.addr == OFS_BYTE_DATA;
  assign erase_req = bus.wr && bus.addr == OFS_SECTOR_ERASE_CONTROL && bus.wdata[BIT_ERASE_GO];
  assign any_req = (prog_req || erase_req) && !tmr_busy;
  assign tmr_start = any_req && s_r.lock == LOCK_OPEN;
  assign tmr_cycles = erase_req ? TIMER_W'(ERASE_CNT) : TIMER_W'(PROGRAM_CNT);

  // status image, upper nibble forced zero
  always_comb begin
    status_val = 8'h00;
    status_val[BIT_OPERATION_IN_PROGRESS] = tmr_busy;
    status_val[BIT_LAST_WAS_PROGRAM] = s_r.last_prog;
    status_val[BIT_LAST_WAS_ERASE] = s_r.last_erase;
  end

  // register and lock logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.addr = addr_nxt;
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_UNLOCK_KEY: s_nxt.lock = key_lock;
        default: begin
        end
      endcase
    end
    // a start consumes the unlock, or kills it when not open
    if (any_req) begin
      if (s_r.lock == LOCK_OPEN) begin
        s_nxt.lock = LOCK_IDLE;
        s_nxt.op_erase = erase_req;
        s_nxt.op_idx = cur_idx;
        s_nxt.pdata = bus.wdata;
      end else begin
        s_nxt.lock = LOCK_DEAD;
      end
    end
    // completion records the operation type
    if (tmr_done) begin
      s_nxt.last_prog = !s_r.op_erase;
      s_nxt.last_erase = s_r.op_erase;
    end
    s_nxt.irq = tmr_done;
    // a read strobe loads the answer flop, held until the next read
    if (bus.rd) begin
      s_nxt.rdata = rd_val;
    end
  end

  // unlock sequencer: two codes in order open exactly one operation
  always_comb begin
    key_lock = s_r.lock;
    unique case (s_r.lock)
      LOCK_IDLE: key_lock = (bus.wdata == KEY_FIRST) ? LOCK_HALF : LOCK_DEAD;
      LOCK_HALF: key_lock = (bus.wdata == KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
      LOCK_OPEN: key_lock = LOCK_DEAD;
      LOCK_DEAD: key_lock = LOCK_DEAD;
    endcase
  end

  // address register: either byte written, auto-read steps it by one
  always_comb begin
    addr_nxt = s_r.addr;
    if (bus.wr && bus.addr == OFS_TARGET_ADDRESS_LOW) begin
      addr_nxt[7:0] = bus.wdata;
    end
    if (bus.wr && bus.addr == OFS_TARGET_ADDRESS_HIGH) begin
      addr_nxt[15:8] = bus.wdata;
    end
    if (bus.rd && bus.addr == OFS_AUTOREAD_DATA) begin
      addr_nxt = s_r.addr + 16'h0001;
    end
  end

  // read multiplexer, open whatever the lock state
  always_comb begin
    rd_val = 8'h00;
    unique case (bus.addr)
      OFS_AUTOREAD_DATA: rd_val = mem_r[cur_idx];
      OFS_BYTE_DATA: rd_val = mem_r[cur_idx];
      OFS_TARGET_ADDRESS_LOW: rd_val = s_r.addr[7:0];
      OFS_TARGET_ADDRESS_HIGH: rd_val = s_r.addr[15:8];
      OFS_NVM_OPERATION_STATUS: rd_val = status_val;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.addr <= ADDR_RESET;
      s_r.lock <= LOCK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // array preset to erased bytes plus station address; contents survive reset
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem_r[i] = ERASED_BYTE;
    end
    for (int j = 0; j < 6; j++) begin
      mem_r[STATION_ADDR_FIRST[MEM_AW-1:0] + MEM_AW'(j)] =
        STATION_ADDR_DEFAULT[47 - 8*j -: 8];
    end
  end

  // wipe strobes for the sector that the finished erase latched at its start
  for (genvar g = 0; g < SECTORS; g++) begin : g_sector
    assign sector_wipe[g] = tmr_done && s_r.op_erase &&
      int'(s_r.op_idx[MEM_AW-1:SECTOR_AW]) == g;
  end
  assign prog_wr = tmr_done && !s_r.op_erase;

  // array write at operation end; plain always since the initial block presets it
  always @(posedge i_ref_clk) begin
    for (int k = 0; k < MEM_BYTES; k++) begin
      if (sector_wipe[k[MEM_AW-1:SECTOR_AW]]) begin
        mem_r[k] <= ERASED_BYTE;
      end
    end
    if (prog_wr) begin
      mem_r[s_r.op_idx] <= mem_r[s_r.op_idx] & s_r.pdata;
    end
  end

  // one timer paces both operations
  nvm_op_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(tmr_start),
    .i_cycles(tmr_cycles),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // bus outputs straight from flops
  assign bus.rdata = s_r.rdata;
  assign bus.irq = s_r.irq;
endmodule

// ===== rtl/nvm_host.sv
module nvm_host (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // user commands
  input wire logic i_prog,
  input wire logic i_erase,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_done,
  // device bus
  nvm_host_if.host bus
);
  import nvm_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_KEY1, H_KEY2, H_ADL, H_ADH, H_GO, H_WAIT} hst_t;
  typedef struct packed {
    hst_t st;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
    logic done;
  } host_t;
  host_t s_r, s_nxt;

  // command sequencer: key, address, start, wait irq
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    bus.addr = 8'h00;
    bus.wdata = 8'h00;
    unique case (s_r.st)
      H_IDLE: begin
        if (i_prog || i_erase) begin
          s_nxt.st = H_KEY1;
          s_nxt.erase = i_erase;
          s_nxt.addr = i_addr;
          s_nxt.data = i_data;
        end
      end
      H_KEY1: begin
        bus.wr = 1'b1;
        bus.addr = OFS_UNLOCK_KEY;
        bus.wdata = KEY_FIRST;
        s_nxt.st = H_KEY2;
      end
      H_KEY2: begin
        bus.wr = 1'b1;
        bus.addr = OFS_UNLOCK_KEY;
        bus.wdata = KEY_SECOND;
        s_nxt.st = H_ADL;
      end
      H_ADL: begin
        bus.wr = 1'b1;
        bus.addr = OFS_TARGET_ADDRESS_LOW;
        bus.wdata = s_r.addr[7:0];
        s_nxt.st = H_ADH;
      end
      H_ADH: begin
        bus.wr = 1'b1;
        bus.addr = OFS_TARGET_ADDRESS_HIGH;
        bus.wdata = s_r.addr[15:8];
        s_nxt.st = H_GO;
      end
      H_GO: begin
        bus.wr = 1'b1;
        bus.addr = s_r.erase ? OFS_SECTOR_ERASE_CONTROL : OFS_BYTE_DATA;
        bus.wdata = s_r.erase ? ERASE_START_VALUE : s_r.data;
        s_nxt.st = H_WAIT;
      end
      H_WAIT: begin
        if (bus.irq) begin
          s_nxt.st = H_IDLE;
          s_nxt.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.st <= H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ready = s_r.st == H_IDLE;
  assign o_done = s_r.done;
endmodule

// ===== rtl/nvm_host_if.sv
interface nvm_host_if;
  import nvm_pkg::*;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic irq;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// ===== rtl/nvm_op_timer.sv
module nvm_op_timer (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // control
  input wire logic i_start,
  input wire logic [nvm_pkg::TIMER_W-1:0] i_cycles,
  // status
  output logic o_busy,
  output logic o_done
);
  import nvm_pkg::*;
  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_t;
  tmr_t s_r, s_nxt;

  // down counter with one-cycle done pulse
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (s_r.busy) begin
      if (s_r.cnt <= TIMER_W'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - TIMER_W'(1);
      end
    end else if (i_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = i_cycles;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = s_r.busy;
  assign o_done = s_r.done;
endmodule

// ===== rtl/nvm_pkg.sv
package nvm_pkg;
  // memory geometry
  localparam int unsigned MEM_BYTES = 8192;
  localparam int unsigned MEM_AW = 13;
  localparam int unsigned SECTOR_AW = 9;
  localparam logic [15:0] STATION_ADDR_FIRST = 16'h1FFA;
  localparam logic [15:0] STATION_ADDR_LAST = 16'h1FFF;
  localparam logic [47:0] STATION_ADDR_DEFAULT = 48'h02_00_00_00_00_01;
  // register offsets
  localparam logic [7:0] OFS_AUTOREAD_DATA = 8'h05;
  localparam logic [7:0] OFS_BYTE_DATA = 8'h06;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h67;
  localparam logic [7:0] OFS_TARGET_ADDRESS_LOW = 8'h68;
  localparam logic [7:0] OFS_TARGET_ADDRESS_HIGH = 8'h69;
  localparam logic [7:0] OFS_SECTOR_ERASE_CONTROL = 8'h6A;
  localparam logic [7:0] OFS_NVM_OPERATION_STATUS = 8'h7B;
  // field positions
  localparam int unsigned BIT_ERASE_GO = 0;
  localparam int unsigned BIT_OPERATION_IN_PROGRESS = 3;
  localparam int unsigned BIT_LAST_WAS_PROGRAM = 1;
  localparam int unsigned BIT_LAST_WAS_ERASE = 0;
  // key codes and values
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ERASE_START_VALUE = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // timing at 200 MHz
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PROGRAM_TIME_US = 55;
  localparam int unsigned ERASE_TIME_MS = 11;
  localparam int unsigned PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TIMER_W = 24;
  // lock states
  typedef enum logic [1:0] {LOCK_IDLE, LOCK_HALF, LOCK_OPEN, LOCK_DEAD} lock_t;
endpackage

// ===== tb/flash_program_erase_control_test.sv
module flash_program_erase_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_prog = 1'b0;
  logic i_erase = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_data = 8'h00;
  logic o_ready, o_done;
  logic [15:0] a, b;
  logic [7:0] d1, d2;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'h7991A904;
  localparam int P_CNT = 20;
  localparam int E_CNT = 50;
  nvm_host_if h_bus();
  nvm_host_if t_bus();
  // host end and device face each other
  nvm_host u_nvm_host (.i_ref_clk, .i_rst, .i_prog, .i_erase, .i_addr, .i_data, .o_ready,
    .o_done, .bus(h_bus.host));
  nvm_device #(.PROGRAM_CNT(P_CNT), .ERASE_CNT(E_CNT)) u_nvm_device (.i_ref_clk, .i_rst,
    .bus(h_bus.device));
  // second device driven by the bench
  nvm_device #(.PROGRAM_CNT(P_CNT), .ERASE_CNT(E_CNT)) u_nvm_device_b (.i_ref_clk, .i_rst,
    .bus(t_bus.device));
  nvm_flash_asserts #(.PROGRAM_CNT(P_CNT), .ERASE_CNT(E_CNT)) u_nvm_flash_asserts (.i_ref_clk,
    .i_rst, .addr(h_bus.addr), .wdata(h_bus.wdata), .rdata(h_bus.rdata), .wr(h_bus.wr),
    .rd(h_bus.rd), .irq(h_bus.irq));
  // clock and run limit
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] progd(input logic [7:0] o, input logic [7:0] n);
    return o & n;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // register write, then an idle cycle
  task automatic bw(input logic [7:0] ad, input logic [7:0] dt);
    t_bus.addr = ad;
    t_bus.wdata = dt;
    t_bus.wr = 1'b1;
    @(posedge i_ref_clk) #1 t_bus.wr = 1'b0;
    @(posedge i_ref_clk) #1;
  endtask
  // register read, checked the cycle after
  task automatic rc(input logic [7:0] ad, input logic [7:0] e);
    t_bus.addr = ad;
    t_bus.rd = 1'b1;
    @(posedge i_ref_clk) #1 t_bus.rd = 1'b0;
    chk(t_bus.rdata, e);
    @(posedge i_ref_clk) #1;
  endtask
  task automatic sa(input logic [15:0] ad);
    bw(OFS_TARGET_ADDRESS_LOW, ad[7:0]);
    bw(OFS_TARGET_ADDRESS_HIGH, ad[15:8]);
  endtask
  task automatic unl();
    bw(OFS_UNLOCK_KEY, KEY_FIRST);
    bw(OFS_UNLOCK_KEY, KEY_SECOND);
  endtask
  // watch irq or host done over a bounded span
  task automatic wt(input logic e, input logic h);
    logic s;
    s = 1'b0;
    repeat (80) begin
      @(posedge i_ref_clk) #1;
      if ((h ? o_done : t_bus.irq) === 1'b1) s = 1'b1;
    end
    chk({7'h00, s}, {7'h00, e});
  endtask
  // keyed operation, busy read, stray start during erase
  task automatic op(input logic [15:0] ad, input logic [7:0] dt, input logic er,
    input logic [7:0] st);
    unl();
    sa(ad);
    if (er) bw(OFS_SECTOR_ERASE_CONTROL, ERASE_START_VALUE);
    else bw(OFS_BYTE_DATA, dt);
    rc(OFS_NVM_OPERATION_STATUS, st);
    if (er) bw(OFS_BYTE_DATA, 8'h00);
    sa(ad ^ 16'h0001);
    wt(1'b1, 1'b0);
    sa(ad);
    rc(OFS_NVM_OPERATION_STATUS, {6'h00, ~er, er});
  endtask
  task automatic do_rst();
    i_rst = 1'b1;
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
  endtask
  initial begin
    t_bus.addr = 8'h00;
    t_bus.wdata = 8'h00;
    t_bus.wr = 1'b0;
    t_bus.rd = 1'b0;
    do_rst();
    // host end: random programs and erases
    for (int i = 0; i < 6; i++) begin
      while (o_ready !== 1'b1) @(posedge i_ref_clk) #1;
      i_addr = 16'($random(seed)) & 16'h1FFF;
      i_data = 8'($random(seed));
      i_erase = i[0];
      i_prog = ~i[0];
      @(posedge i_ref_clk) #1;
      i_erase = 1'b0;
      i_prog = 1'b0;
      wt(1'b1, 1'b1);
    end
    // station address, auto-read walk, fixed reads
    sa(STATION_ADDR_FIRST);
    for (int i = 0; i < 6; i++) rc(OFS_AUTOREAD_DATA, STATION_ADDR_DEFAULT[47-8*i -: 8]);
    rc(OFS_TARGET_ADDRESS_HIGH, 8'h20);
    rc(OFS_TARGET_ADDRESS_LOW, 8'h00);
    rc(OFS_NVM_OPERATION_STATUS, STATUS_RESET);
    rc(OFS_UNLOCK_KEY, 8'h00);
    rc(8'h00, 8'h00);
    // program byte a twice, erase the top sector, then program byte b
    a = {7'h00, 9'($random(seed))};
    b = {7'h01, 9'($random(seed))};
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    sa(a);
    rc(OFS_BYTE_DATA, ERASED_BYTE);
    op(a, d1, 1'b0, 8'h08);
    rc(OFS_BYTE_DATA, d1);
    op(a, d2, 1'b0, 8'h0A);
    rc(OFS_BYTE_DATA, progd(d1, d2));
    op({7'h0F, 9'($random(seed))}, 8'h00, 1'b1, 8'h0A);
    sa(STATION_ADDR_LAST);
    rc(OFS_BYTE_DATA, ERASED_BYTE);
    sa(a);
    rc(OFS_BYTE_DATA, progd(d1, d2));
    op(b, d1, 1'b0, 8'h09);
    // spent unlock: start refused, device locked out
    bw(OFS_BYTE_DATA, d2);
    unl();
    bw(OFS_SECTOR_ERASE_CONTROL, ERASE_START_VALUE);
    wt(1'b0, 1'b0);
    rc(OFS_NVM_OPERATION_STATUS, 8'h02);
    rc(OFS_BYTE_DATA, d1);
    // reset clears lock; a wrong code locks again
    do_rst();
    rc(OFS_NVM_OPERATION_STATUS, STATUS_RESET);
    bw(OFS_UNLOCK_KEY, KEY_FIRST);
    bw(OFS_UNLOCK_KEY, 8'h5A);
    bw(OFS_UNLOCK_KEY, KEY_SECOND);
    sa(b);
    bw(OFS_BYTE_DATA, 8'h00);
    wt(1'b0, 1'b0);
    rc(OFS_BYTE_DATA, d1);
    do_rst();
    op(b, 8'h00, 1'b0, 8'h08);
    rc(OFS_BYTE_DATA, 8'h00);
    tally_and_finish();
  end
endmodule

// ===== tb/nvm_flash_asserts.sv
module nvm_flash_asserts
  import nvm_pkg::*;
#(parameter int PROGRAM_CNT = 20, parameter int ERASE_CNT = 50) (
  // bus signals
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic irq
);
  localparam int P_LO = PROGRAM_CNT - 1, P_HI = PROGRAM_CNT + 4;
  localparam int E_LO = ERASE_CNT - 1, E_HI = ERASE_CNT + 4;
  logic key_r, busy_r, st;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // operation steps on the bus
  sequence s_key1; wr && addr == OFS_UNLOCK_KEY && wdata == KEY_FIRST; endsequence
  sequence s_key2; wr && addr == OFS_UNLOCK_KEY && wdata == KEY_SECOND; endsequence
  sequence s_prog; wr && addr == OFS_BYTE_DATA; endsequence
  sequence s_erase; wr && addr == OFS_SECTOR_ERASE_CONTROL; endsequence
  assign st = wr && (addr == OFS_BYTE_DATA || addr == OFS_SECTOR_ERASE_CONTROL);
  // unlock seen, operation pending
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      key_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (wr && addr == OFS_UNLOCK_KEY) key_r <= wdata == KEY_SECOND;
      else if (st) key_r <= 1'b0;
      if (irq) busy_r <= 1'b0;
      else if (st) busy_r <= 1'b1;
    end
  end
  a_irq_single: assert property (irq |=> !irq) else $error("wide irq");
  a_irq_cause: assert property (irq |-> busy_r) else $error("stray irq");
  a_prog_time: assert property (s_prog |-> ##[P_LO:P_HI] irq) else $error("prog end");
  a_erase_time: assert property (s_erase |-> ##[E_LO:E_HI] irq) else $error("erase end");
  a_key_pair: assert property (s_key1 |-> ##[1:4] s_key2) else $error("key order");
  a_start_keyed: assert property (st |-> key_r) else $error("start unkeyed");
  a_erase_go: assert property (s_erase |-> wdata == ERASE_START_VALUE) else $error("erase value");
  a_busy_start: assert property (busy_r |-> !st) else $error("start while busy");
endmodule
